// ==== anrx_params.svh ====
// constants for the auto-negotiation receive match detectors and link timer
`ifndef ANRX_PARAMS_SVH
`define ANRX_PARAMS_SVH

`define ANRX_WORD_W 16
`define ANRX_ACK_BIT 14
`define ANRX_MATCH_MASK 16'hBFFF
`define ANRX_CNT_W 2
`define ANRX_CNT_ZERO 2'h0
`define ANRX_CNT_ONE 2'h1
`define ANRX_CNT_FULL 2'h3
`define ANRX_WORD_ZERO 16'h0000
`define ANRX_ADV_ABILITY_DEFAULT 16'h0000
`define ANRX_CLK_PERIOD_NS 10
`define ANRX_LINK_TIMER_NS 10000000
`define ANRX_LINK_TIMER_CYCLES ((`ANRX_LINK_TIMER_NS + `ANRX_CLK_PERIOD_NS - 1) / `ANRX_CLK_PERIOD_NS)

`endif

// ==== anrx_pkg.sv ====
// types shared by the auto-negotiation receive match detector
package anrx_pkg;

   // link timer sequencing, one-hot
   typedef enum logic [2:0] {
      ANRX_TMR_IDLE = 3'h1,
      ANRX_TMR_RUN = 3'h2,
      ANRX_TMR_EXPIRED = 3'h4
   } anrx_tmr_state_t;

endpackage

// ==== anrx_match_detect.sv ====
// receive-side match detectors and link timer for 1000BASE-X auto-negotiation
// Functional notes
// - acknowledge_match: last three config words identical and each with Acknowledge set.
// - consecutive means back-to-back /C/ sets; words may be reused in new matches.
// - an /I/ ordered set clears the acknowledge match count.
// - second or third word differing from the first restarts acknowledge count at one.
// - acknowledge_match defaults FALSE and reads FALSE after every state entry.
// - a change of the enable control drives an_enable_change TRUE.
// - an_enable_change defaults FALSE and returns FALSE on state entry unless a new change arrives in the entry cycle.
// - consistency_match: ability word equals acknowledge word, Acknowledge bit ignored.
// - ability word captured on entry into acknowledge-detect.
// - idle_match after three back-to-back /I/ ordered sets.
// - a /C/ ordered set clears the idle match count.
// - idle_match defaults FALSE and reads FALSE after every state entry.
// - link timer runs nominal 10 ms, never early, at most 10 ms late.
// - link timer paces negotiation and leaves management time between steps.
// - fixed advertised ability value provided when no management exists.
// - ability_match: three identical words on D15,D13:D0; cleared by /I/ or mismatch.
`include "anrx_params.svh"

module anrx_match_detect #(
   parameter int unsigned LINK_TIMER_CYCLES = `ANRX_LINK_TIMER_CYCLES,
   parameter logic [`ANRX_WORD_W-1:0] ADV_ABILITY = `ANRX_ADV_ABILITY_DEFAULT
) (
   input wire logic clock,
   input wire logic srst,
   input wire logic rx_set_valid,
   input wire logic rx_set_is_config,
   input wire logic [`ANRX_WORD_W-1:0] rx_config_word,
   input wire logic state_entry,
   input wire logic enter_ack_detect,
   input wire logic an_enable,
   input wire logic link_timer_start,
   output logic ability_match,
   output logic acknowledge_match,
   output logic consistency_match,
   output logic idle_match,
   output logic an_enable_change,
   output logic an_enable_level,
   output logic link_timer_done,
   output logic [`ANRX_WORD_W-1:0] adv_ability
);

   localparam int TMR_W = (LINK_TIMER_CYCLES > 1) ? $clog2(LINK_TIMER_CYCLES) : 1;
   localparam logic [TMR_W-1:0] TMR_LOAD = TMR_W'(LINK_TIMER_CYCLES - 1);
   localparam logic [TMR_W-1:0] TMR_ZERO = '0;

   // ordered set classification
   wire is_c = rx_set_valid & rx_set_is_config;
   wire is_i = rx_set_valid & ~rx_set_is_config;

   // ---------------- ability match ----------------
   logic [`ANRX_CNT_W-1:0] abil_cnt;
   logic [`ANRX_WORD_W-1:0] abil_ref;
   wire [`ANRX_WORD_W-1:0] rx_masked = rx_config_word & `ANRX_MATCH_MASK;
   wire abil_same = (rx_masked == abil_ref);
   wire abil_restart = (abil_cnt == `ANRX_CNT_ZERO) | ~abil_same;
   wire [`ANRX_CNT_W-1:0] abil_inc = (abil_cnt == `ANRX_CNT_FULL) ? abil_cnt : abil_cnt + `ANRX_CNT_ONE;
   // ability count compare
   // a mismatching word restarts the count as the new first word
   wire [`ANRX_CNT_W-1:0] next_abil_cnt = is_i ? `ANRX_CNT_ZERO :
                                          !is_c ? abil_cnt :
                                          abil_restart ? `ANRX_CNT_ONE : abil_inc;
   wire [`ANRX_WORD_W-1:0] next_abil_ref = (is_c & abil_restart) ? rx_masked : abil_ref;
   wire next_ability_match = ~state_entry & (next_abil_cnt == `ANRX_CNT_FULL);

   // ability tracking registers
   always_ff @(posedge clock) begin
      if (srst) begin
         abil_cnt <= `ANRX_CNT_ZERO;
         abil_ref <= `ANRX_WORD_ZERO;
         ability_match <= 1'b0;
      end else begin
         abil_cnt <= next_abil_cnt;
         abil_ref <= next_abil_ref;
         ability_match <= next_ability_match;
      end
   end

   // ---------------- acknowledge match ----------------
   logic [`ANRX_CNT_W-1:0] ack_cnt;
   logic [`ANRX_WORD_W-1:0] ack_ref;
   wire ack_same = (rx_config_word == ack_ref);
   wire ack_restart = (ack_cnt == `ANRX_CNT_ZERO) | ~ack_same;
   wire [`ANRX_CNT_W-1:0] ack_inc = (ack_cnt == `ANRX_CNT_FULL) ? ack_cnt : ack_cnt + `ANRX_CNT_ONE;
   // sliding window reuse
   // saturating at full lets every further equal word keep the match alive
   // idle clears count
   wire [`ANRX_CNT_W-1:0] next_ack_cnt = is_i ? `ANRX_CNT_ZERO :
                                         !is_c ? ack_cnt :
                                         ack_restart ? `ANRX_CNT_ONE : ack_inc;
   wire [`ANRX_WORD_W-1:0] next_ack_ref = (is_c & ack_restart) ? rx_config_word : ack_ref;
   wire next_ack_bit = next_ack_ref[`ANRX_ACK_BIT];
   wire next_ack_match = ~state_entry & (next_ack_cnt == `ANRX_CNT_FULL) & next_ack_bit;

   // acknowledge tracking registers
   always_ff @(posedge clock) begin
      if (srst) begin
         ack_cnt <= `ANRX_CNT_ZERO;
         ack_ref <= `ANRX_WORD_ZERO;
         acknowledge_match <= 1'b0;
      end else begin
         ack_cnt <= next_ack_cnt;
         ack_ref <= next_ack_ref;
         acknowledge_match <= next_ack_match;
      end
   end

   // ---------------- consistency ----------------
   logic [`ANRX_WORD_W-1:0] abil_capt;
   wire [`ANRX_WORD_W-1:0] next_abil_capt = enter_ack_detect ? abil_ref : abil_capt;
   // compare without ack
   // the ack word is masked here and the ability word already excludes D14, so the acknowledge bit never decides
   wire capt_equal = ((next_ack_ref & `ANRX_MATCH_MASK) == next_abil_capt);
   wire next_consistency = next_ack_match & capt_equal;

   // consistency registers
   always_ff @(posedge clock) begin
      if (srst) begin
         abil_capt <= `ANRX_WORD_ZERO;
         consistency_match <= 1'b0;
      end else begin
         abil_capt <= next_abil_capt;
         consistency_match <= next_consistency;
      end
   end

   // ---------------- idle match ----------------
   logic [`ANRX_CNT_W-1:0] idle_cnt;
   wire [`ANRX_CNT_W-1:0] idle_inc = (idle_cnt == `ANRX_CNT_FULL) ? idle_cnt : idle_cnt + `ANRX_CNT_ONE;
   wire [`ANRX_CNT_W-1:0] next_idle_cnt = is_c ? `ANRX_CNT_ZERO : (is_i ? idle_inc : idle_cnt);
   wire next_idle_match = ~state_entry & (next_idle_cnt == `ANRX_CNT_FULL);

   // idle registers
   always_ff @(posedge clock) begin
      if (srst) begin
         idle_cnt <= `ANRX_CNT_ZERO;
         idle_match <= 1'b0;
      end else begin
         idle_cnt <= next_idle_cnt;
         idle_match <= next_idle_match;
      end
   end

   // ---------------- enable change detect ----------------
   logic en_s1;
   logic en_s2;
   logic en_s3;
   logic en_primed;
   // enable bit from management
   // a change counts only once the second and third stage agree
   wire en_agree = (en_s2 == en_s3);
   // first agreement after reset loads the level silently, no false change
   // detect enable change
   wire en_new_change = en_agree & en_primed & (en_s3 != an_enable_level);
   // clear on entry
   // a change in the entry cycle wins over the clear
   wire next_change = en_new_change | (an_enable_change & ~state_entry);
   wire next_en_level = en_agree ? en_s3 : an_enable_level;

   // synchroniser and change flag
   always_ff @(posedge clock) begin
      if (srst) begin
         en_s1 <= 1'b0;
         en_s2 <= 1'b0;
         en_s3 <= 1'b0;
         en_primed <= 1'b0;
         an_enable_level <= 1'b0;
         an_enable_change <= 1'b0;
      end else begin
         en_s1 <= an_enable;
         en_s2 <= en_s1;
         en_s3 <= en_s2;
         en_primed <= en_primed | en_agree;
         an_enable_level <= next_en_level;
         an_enable_change <= next_change;
      end
   end

   // ---------------- link timer ----------------
   anrx_pkg::anrx_tmr_state_t tmr_state;
   anrx_pkg::anrx_tmr_state_t next_tmr_state;
   logic [TMR_W-1:0] tmr_cnt;
   logic [TMR_W-1:0] next_tmr_cnt;

   always_comb begin
      next_tmr_state = tmr_state;
      next_tmr_cnt = tmr_cnt;
      if (link_timer_start) begin
         next_tmr_state = anrx_pkg::ANRX_TMR_RUN;
         next_tmr_cnt = TMR_LOAD;
      end else begin
         case (tmr_state)
            anrx_pkg::ANRX_TMR_IDLE: begin
               next_tmr_state = anrx_pkg::ANRX_TMR_IDLE;
            end
            anrx_pkg::ANRX_TMR_RUN: begin
               if (tmr_cnt == TMR_ZERO) begin
                  next_tmr_state = anrx_pkg::ANRX_TMR_EXPIRED;
               end else begin
                  next_tmr_cnt = tmr_cnt - TMR_W'(1);
               end
            end
            anrx_pkg::ANRX_TMR_EXPIRED: begin
               next_tmr_state = anrx_pkg::ANRX_TMR_EXPIRED;
            end
            default: begin
               next_tmr_state = anrx_pkg::ANRX_TMR_IDLE;
            end
         endcase
      end
   end

   // timer registers and fixed advertised ability
   always_ff @(posedge clock) begin
      if (srst) begin
         tmr_state <= anrx_pkg::ANRX_TMR_IDLE;
         tmr_cnt <= TMR_ZERO;
         link_timer_done <= 1'b0;
         adv_ability <= `ANRX_WORD_ZERO;
      end else begin
         tmr_state <= next_tmr_state;
         tmr_cnt <= next_tmr_cnt;
         link_timer_done <= (next_tmr_state == anrx_pkg::ANRX_TMR_EXPIRED);
         adv_ability <= ADV_ABILITY;
      end
   end

   // ---------------- checks ----------------
   // elapsed cycles since the last start, saturating, for the timer check
   logic [TMR_W:0] chk_elapsed;
   always_ff @(posedge clock) begin
      if (srst) begin
         chk_elapsed <= '0;
      end else if (link_timer_start) begin
         chk_elapsed <= '0;
      end else if (chk_elapsed[TMR_W] == 1'b0) begin
         chk_elapsed <= chk_elapsed + (TMR_W+1)'(1);
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);

   property p_ack_needs_bit;
      acknowledge_match |-> ack_ref[`ANRX_ACK_BIT] && ack_cnt == `ANRX_CNT_FULL;
   endproperty
   a_ack_needs_bit: assert property (p_ack_needs_bit) else $error("ack match without ack bit or count");

   property p_ack_slide;
      is_c && ack_same && ack_cnt == `ANRX_CNT_FULL && ack_ref[`ANRX_ACK_BIT] && !state_entry |=> acknowledge_match;
   endproperty
   a_ack_slide: assert property (p_ack_slide) else $error("repeated word dropped ack match");

   property p_ack_idle_clear;
      is_i |=> !acknowledge_match && ack_cnt == `ANRX_CNT_ZERO;
   endproperty
   a_ack_idle_clear: assert property (p_ack_idle_clear) else $error("idle did not clear ack count");

   property p_ack_mismatch;
      is_c && ack_cnt != `ANRX_CNT_ZERO && !ack_same |=> ack_cnt == `ANRX_CNT_ONE && !acknowledge_match;
   endproperty
   a_ack_mismatch: assert property (p_ack_mismatch) else $error("mismatch did not restart ack count");

   property p_entry_default;
      state_entry |=> !acknowledge_match && !idle_match && !ability_match;
   endproperty
   a_entry_default: assert property (p_entry_default) else $error("flag not default after state entry");

   property p_enable_change;
      en_new_change |=> an_enable_change ##1 (an_enable_change || $past(state_entry));
   endproperty
   a_enable_change: assert property (p_enable_change) else $error("enable change not flagged");

   property p_change_clear;
      state_entry && !en_new_change |=> !an_enable_change;
   endproperty
   a_change_clear: assert property (p_change_clear) else $error("change flag not cleared on entry");

   property p_consistency;
      consistency_match |-> acknowledge_match && ((ack_ref & `ANRX_MATCH_MASK) == abil_capt);
   endproperty
   a_consistency: assert property (p_consistency) else $error("consistency without equal words");

   property p_capture;
      enter_ack_detect |=> abil_capt == $past(abil_ref);
   endproperty
   a_capture: assert property (p_capture) else $error("ability word not captured");

   property p_idle_three;
      is_i && idle_cnt == (`ANRX_CNT_FULL - `ANRX_CNT_ONE) && !state_entry |=> idle_match;
   endproperty
   a_idle_three: assert property (p_idle_three) else $error("third idle did not set idle match");

   property p_idle_c_clear;
      is_c |=> !idle_match && idle_cnt == `ANRX_CNT_ZERO;
   endproperty
   a_idle_c_clear: assert property (p_idle_c_clear) else $error("config set did not clear idle");

   property p_timer_not_early;
      link_timer_done |-> chk_elapsed >= (TMR_W+1)'(LINK_TIMER_CYCLES);
   endproperty
   a_timer_not_early: assert property (p_timer_not_early) else $error("link timer expired early");

   property p_timer_hold;
      link_timer_done && !link_timer_start |=> link_timer_done;
   endproperty
   a_timer_hold: assert property (p_timer_hold) else $error("timer done dropped before restart");

   property p_ability_three;
      is_c && abil_same && abil_cnt == (`ANRX_CNT_FULL - `ANRX_CNT_ONE) && !state_entry |=> ability_match;
   endproperty
   a_ability_three: assert property (p_ability_three) else $error("third equal word missed ability match");

   property p_adv_fixed;
      !srst |=> adv_ability == ADV_ABILITY;
   endproperty
   a_adv_fixed: assert property (p_adv_fixed) else $error("advertised ability not fixed");

   c_ack_match: cover property (!acknowledge_match ##1 acknowledge_match);
   c_consistent: cover property (consistency_match);
   c_idle_match: cover property (idle_match);
   c_timer_done: cover property (!link_timer_done ##1 link_timer_done);

endmodule // anrx_match_detect

// ==== anrx_pcs_rx_model.sv ====
// pcs receive path model that hands ordered sets to the match detector
`include "anrx_params.svh"

module anrx_pcs_rx_model (
   input wire logic clock,
   output logic rx_set_valid,
   output logic rx_set_is_config,
   output logic [`ANRX_WORD_W-1:0] rx_config_word
);
   timeunit 1ns;
   timeprecision 1ps;

   // lines start quiet with a junk word
   initial begin
      rx_set_valid = 1'b0;
      rx_set_is_config = 1'b0;
      rx_config_word = 16'hA5C3;
   end

   // back-to-back sets
   // launched just after one edge, taken at the next; calls may follow with no gap
   task automatic send_config(input logic [`ANRX_WORD_W-1:0] word);
      @(posedge clock);
      rx_set_valid <= 1'b1;
      rx_set_is_config <= 1'b1;
      rx_config_word <= word;
   endtask

   // idle set, the word lines carry nothing useful
   task automatic send_idle();
      @(posedge clock);
      rx_set_valid <= 1'b1;
      rx_set_is_config <= 1'b0;
      rx_config_word <= ~rx_config_word;
   endtask

   // released lines flip: a stale word left standing could fake a match
   task automatic go_quiet();
      @(posedge clock);
      rx_set_valid <= 1'b0;
      rx_set_is_config <= ~rx_set_is_config;
      rx_config_word <= ~rx_config_word;
   endtask
endmodule // anrx_pcs_rx_model

// ==== anrx_match_detect_tb.sv ====
// self-checking bench for the auto-negotiation receive match detectors
`include "anrx_params.svh"

module anrx_match_detect_tb;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int TMR_CYCLES = 20;
   localparam logic [15:0] ADV_W = 16'h5A3C;
   localparam logic [15:0] ACK_W = 16'h41A5;
   localparam logic [15:0] NOACK_W = 16'h01A5;
   localparam logic [15:0] ALT_W = 16'h41A4;

   logic clock, srst, state_entry, enter_ack_detect, an_enable, link_timer_start;
   wire logic rx_set_valid, rx_set_is_config;
   wire logic [15:0] rx_config_word, adv_ability;
   wire logic ability_match, acknowledge_match, consistency_match, idle_match;
   wire logic an_enable_change, an_enable_level, link_timer_done;
   int n_mismatch = 0;
   int check_count = 0;

   anrx_pcs_rx_model u_pcs (
      .clock(clock), .rx_set_valid(rx_set_valid), .rx_set_is_config(rx_set_is_config),
      .rx_config_word(rx_config_word)
   );

   anrx_match_detect #(.LINK_TIMER_CYCLES(TMR_CYCLES), .ADV_ABILITY(ADV_W)) u_dut (
      .clock(clock), .srst(srst), .rx_set_valid(rx_set_valid), .rx_set_is_config(rx_set_is_config),
      .rx_config_word(rx_config_word), .state_entry(state_entry), .enter_ack_detect(enter_ack_detect),
      .an_enable(an_enable), .link_timer_start(link_timer_start), .ability_match(ability_match),
      .acknowledge_match(acknowledge_match), .consistency_match(consistency_match),
      .idle_match(idle_match), .an_enable_change(an_enable_change), .an_enable_level(an_enable_level),
      .link_timer_done(link_timer_done), .adv_ability(adv_ability)
   );

   // free-running 100 MHz clock
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   // compare tasks, one per result width
   task automatic check_bit(input logic got, input logic exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // three equal words then a gap; flags are settled on return
   task automatic send3(input logic [15:0] word);
      repeat (3) u_pcs.send_config(word);
      u_pcs.go_quiet();
      #1;
   endtask
   task automatic idle_then_quiet();
      u_pcs.send_idle();
      u_pcs.go_quiet();
      #1;
   endtask
   task automatic pulse_entry();
      @(posedge clock);
      state_entry <= 1'b1;
      @(posedge clock);
      state_entry <= 1'b0;
      #1;
   endtask
   // enable passes a synchroniser, so allow a few edges
   // management sets or clears enable
   task automatic toggle_enable(input logic lvl);
      int n;
      n = 0;
      @(posedge clock);
      an_enable <= lvl;
      while (an_enable_change !== 1'b1 && n < 8) begin
         @(posedge clock);
         #1;
         n++;
      end
   endtask
   task automatic start_timer();
      @(posedge clock);
      link_timer_start <= 1'b1;
      @(posedge clock);
      link_timer_start <= 1'b0;
      #1;
   endtask

   task automatic test_reset();
      repeat (6) @(posedge clock);
      #1;
      check_word(adv_ability, ADV_W);
      check_bit(acknowledge_match, 1'b0);
      check_bit(idle_match, 1'b0);
      check_bit(an_enable_change, 1'b0);
      $display("test reset done");
   endtask

   task automatic test_ack();
      send3(ACK_W);
      check_bit(acknowledge_match, 1'b1);
      check_bit(ability_match, 1'b1);
      u_pcs.send_config(ACK_W);
      u_pcs.go_quiet();
      #1;
      check_bit(acknowledge_match, 1'b1);
      idle_then_quiet();
      check_bit(acknowledge_match, 1'b0);
      check_bit(ability_match, 1'b0);
      send3(NOACK_W);
      check_bit(acknowledge_match, 1'b0);
      check_bit(ability_match, 1'b1);
      idle_then_quiet();
      repeat (2) u_pcs.send_config(ACK_W);
      u_pcs.go_quiet();
      #1;
      check_bit(acknowledge_match, 1'b0);
      // a differing third word drops the run and counts as a new first word
      u_pcs.send_config(ALT_W);
      u_pcs.go_quiet();
      #1;
      check_bit(acknowledge_match, 1'b0);
      check_bit(ability_match, 1'b0);
      repeat (2) u_pcs.send_config(ALT_W);
      u_pcs.go_quiet();
      #1;
      check_bit(acknowledge_match, 1'b1);
      $display("test ack done");
   endtask

   task automatic test_idle_entry();
      repeat (2) idle_then_quiet();
      check_bit(idle_match, 1'b0);
      idle_then_quiet();
      check_bit(idle_match, 1'b1);
      pulse_entry();
      check_bit(idle_match, 1'b0);
      @(posedge clock);
      #1;
      check_bit(idle_match, 1'b1);
      send3(ACK_W);
      check_bit(idle_match, 1'b0);
      pulse_entry();
      check_bit(acknowledge_match, 1'b0);
      @(posedge clock);
      #1;
      check_bit(acknowledge_match, 1'b1);
      $display("test idle and entry done");
   endtask

   task automatic test_consist();
      idle_then_quiet();
      send3(NOACK_W);
      @(posedge clock);
      enter_ack_detect <= 1'b1;
      @(posedge clock);
      enter_ack_detect <= 1'b0;
      send3(ACK_W);
      check_bit(consistency_match, 1'b1);
      send3(ACK_W ^ 16'h8000);
      check_bit(acknowledge_match, 1'b1);
      check_bit(consistency_match, 1'b0);
      $display("test consistency done");
   endtask

   task automatic test_enable();
      toggle_enable(1'b1);
      check_bit(an_enable_change, 1'b1);
      check_bit(an_enable_level, 1'b1);
      pulse_entry();
      check_bit(an_enable_change, 1'b0);
      toggle_enable(1'b0);
      check_bit(an_enable_change, 1'b1);
      check_bit(an_enable_level, 1'b0);
      $display("test enable done");
   endtask

   task automatic test_timer();
      start_timer();
      check_bit(link_timer_done, 1'b0);
      repeat (8) @(posedge clock);
      start_timer();
      repeat (TMR_CYCLES - 1) @(posedge clock);
      #1;
      check_bit(link_timer_done, 1'b0);
      @(posedge clock);
      #1;
      check_bit(link_timer_done, 1'b1);
      repeat (5) @(posedge clock);
      #1;
      check_bit(link_timer_done, 1'b1);
      start_timer();
      check_bit(link_timer_done, 1'b0);
      $display("test timer done");
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // main sequence
   initial begin
      srst = 1'b1;
      state_entry = 1'b0;
      enter_ack_detect = 1'b0;
      an_enable = 1'b0;
      link_timer_start = 1'b0;
      repeat (5) @(posedge clock);
      srst <= 1'b0;
      test_reset();
      test_ack();
      test_idle_entry();
      test_consist();
      test_enable();
      test_timer();
      final_report();
   end

   // hang guard, well beyond the hundred or so cycles the tests need
   initial begin
      repeat (4000) @(posedge clock);
      n_mismatch++;
      final_report();
   end
endmodule // anrx_match_detect_tb
